// ==== rtl/pagpio_pkg.sv ====
package pagpio_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [19:0] DIR_IDX = 20'hEE009;
  localparam logic [19:0] DATA_IDX = 20'hFFFD9;
  localparam logic [19:0] PAT_EN_IDX = 20'h00001;
  localparam logic [19:0] TMR_CTL_IDX = 20'h00002;
  localparam logic [19:0] BUS_REL_IDX = 20'h00003;
  localparam logic [19:0] STATUS_IDX = 20'h00004;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 21;
  // ==========================================================
  // reset values, and the fixed direction read value
  localparam logic [7:0] DIR_RST_NORMAL = 8'h00;
  localparam logic [7:0] DIR_RST_ADDR = 8'h80;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] PAT_EN_RST = 8'h00;
  localparam logic [17:0] TMR_CTL_RST = 18'h00000;
  localparam logic [3:0] BUS_REL_RST = 4'hF;
  localparam logic [7:0] DIR_READ_VAL = 8'hFF;
  // ==========================================================
  // timer control field positions
  localparam int C1A_LSB = 0;
  localparam int C1B_LSB = 4;
  localparam int C2A_LSB = 8;
  localparam int C2B_LSB = 12;
  localparam int C1_PWM_BIT = 16;
  localparam int C2_PWM_BIT = 17;
  // status field positions
  localparam int ST_MODE_LSB = 16;
  localparam int ST_OE_LSB = 8;
  // ==========================================================
  // operating modes
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } pagpio_axil_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } pagpio_axil_rsp_t;
endpackage : pagpio_pkg

// ==== rtl/pagpio_chan_hold.sv ====
`timescale 1ns/1ps
// holds one bus channel item until the write can complete
module pagpio_chan_hold #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  input wire logic valid,
  input wire logic [W-1:0] payload,
  output logic ready,
  // draining side
  input wire logic take,
  output logic full,
  output logic [W-1:0] held
);
  logic full_q;
  logic [W-1:0] held_q;
  assign ready = !full_q;
  assign full = full_q;
  assign held = held_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      full_q <= 1'b0;
    end else if (valid && !full_q) begin
      full_q <= 1'b1;
    end else if (take) begin
      full_q <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      held_q <= '0;
    end else if (valid && !full_q) begin
      held_q <= payload;
    end
  end
endmodule : pagpio_chan_hold

// ==== rtl/pagpio_pinsel.sv ====
`timescale 1ns/1ps
// function selector for one port pin
module pagpio_pinsel #(
  parameter bit B_SIDE = 1'b0
) (
  // generic port
  input wire logic dir,
  input wire logic data,
  input wire logic pat_en,
  input wire logic pat_val,
  // timer
  input wire logic pwm,
  input wire logic [2:0] io_ctl,
  input wire logic cmp_val,
  // address override
  input wire logic addr_sel,
  input wire logic addr_val,
  // pin side
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic cap_out
);
  logic cmp_sel;
  logic cap_sel;
  always_comb begin
    if (B_SIDE) begin
      cmp_sel = !io_ctl[2] && (io_ctl[1:0] != 2'h0);
      cap_sel = io_ctl[2] && !pwm;
    end else begin
      cmp_sel = !io_ctl[2] && (pwm || (io_ctl[1:0] != 2'h0));
      cap_sel = io_ctl[2];
    end
  end
  // capture taps the pin beside the generic input path
  assign cap_out = cap_sel && pin_in;
  // address first, then compare, then pattern, then plain data
  always_comb begin
    pin_out = 1'b0;
    pin_oe = 1'b0;
    if (addr_sel) begin
      pin_out = addr_val;
      pin_oe = 1'b1;
    end else if (cmp_sel) begin
      pin_out = cmp_val;
      pin_oe = 1'b1;
    end else if (dir) begin
      pin_out = pat_en ? pat_val : data;
      pin_oe = 1'b1;
    end
  end
endmodule : pagpio_pinsel

// ==== rtl/pagpio_top.sv ====
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
module pagpio_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire pagpio_pkg::pagpio_axil_req_t axil_req,
  output pagpio_pkg::pagpio_axil_rsp_t axil_rsp,
  // chip state
  input wire logic [2:0] mode,
  input wire logic hw_standby,
  input wire logic sw_standby,
  // peripheral sources
  input wire logic [7:0] pattern_val,
  input wire logic chan1_a_cmp,
  input wire logic chan1_b_cmp,
  input wire logic chan2_a_cmp,
  input wire logic chan2_b_cmp,
  input wire logic [3:0] addr_hi,
  // capture taps
  output logic chan1_a_cap,
  output logic chan1_b_cap,
  output logic chan2_a_cap,
  output logic chan2_b_cap,
  // port pins
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe
);
  // ==========================================================
  // mode decode
  logic addr_mode;
  logic exp_mode;
  logic regs_clear;
  assign addr_mode = (mode == pagpio_pkg::MODE_3) ||
                     (mode == pagpio_pkg::MODE_4);
  assign exp_mode = (mode == pagpio_pkg::MODE_5);
  // hardware standby clears like reset; software standby does not,
  // so outputs keep driving through it
  assign regs_clear = !rst_n || hw_standby;

  // ==========================================================
  // write channel holding
  logic aw_full;
  logic w_full;
  logic [31:0] aw_addr;
  logic [35:0] w_held;
  logic wr_go;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_ready;
  logic w_ready;

  // write completes once both halves are held and no answer waits
  assign wr_go = aw_full && w_full && !bvalid_q;

  pagpio_chan_hold #(
    .W(32)
  ) u_aw_hold (
    .clk(clk),
    .rst_n(rst_n),
    .valid(axil_req.awvalid),
    .payload(axil_req.awaddr),
    .ready(aw_ready),
    .take(wr_go),
    .full(aw_full),
    .held(aw_addr)
  );

  pagpio_chan_hold #(
    .W(36)
  ) u_w_hold (
    .clk(clk),
    .rst_n(rst_n),
    .valid(axil_req.wvalid),
    .payload({axil_req.wstrb, axil_req.wdata}),
    .ready(w_ready),
    .take(wr_go),
    .full(w_full),
    .held(w_held)
  );

  // ==========================================================
  // write decode
  logic [31:0] wr_data;
  logic wr_lane0;
  logic wr_lane1;
  logic wr_lane2;
  logic wr_hi_zero;
  logic wr_dir;
  logic wr_dat;
  logic wr_pat;
  logic wr_tmr;
  logic wr_bus;
  logic wr_hit;

  assign wr_data = w_held[31:0];
  assign wr_lane0 = w_held[32];
  assign wr_lane1 = w_held[33];
  assign wr_lane2 = w_held[34];
  assign wr_hi_zero = (aw_addr[31:pagpio_pkg::IDX_MSB+1] == '0);
  always_comb begin
    wr_dir = 1'b0;
    wr_dat = 1'b0;
    wr_pat = 1'b0;
    wr_tmr = 1'b0;
    wr_bus = 1'b0;
    if (wr_hi_zero) begin
      case (aw_addr[pagpio_pkg::IDX_MSB:pagpio_pkg::IDX_LSB])
        pagpio_pkg::DIR_IDX: wr_dir = 1'b1;
        pagpio_pkg::DATA_IDX: wr_dat = 1'b1;
        pagpio_pkg::PAT_EN_IDX: wr_pat = 1'b1;
        pagpio_pkg::TMR_CTL_IDX: wr_tmr = 1'b1;
        pagpio_pkg::BUS_REL_IDX: wr_bus = 1'b1;
        default: wr_dir = 1'b0;
      endcase
    end
  end
  // status is read-only and answers a write with an error
  assign wr_hit = wr_dir || wr_dat || wr_pat || wr_tmr || wr_bus;

  // ==========================================================
  // port direction
  logic [7:0] dir_q;
  always_ff @(posedge clk) begin
    if (regs_clear) begin
      dir_q <= addr_mode ? pagpio_pkg::DIR_RST_ADDR
                         : pagpio_pkg::DIR_RST_NORMAL;
    end else if (wr_go && wr_dir && wr_lane0) begin
      dir_q[6:0] <= wr_data[6:0];
      // address pin direction stays set in modes 3 and 4
      dir_q[7] <= addr_mode ? 1'b1 : wr_data[7];
    end
  end

  // ==========================================================
  // port output data
  logic [7:0] data_q;
  always_ff @(posedge clk) begin
    if (regs_clear) begin
      data_q <= pagpio_pkg::DATA_RST;
    end else if (wr_go && wr_dat && wr_lane0) begin
      data_q <= wr_data[7:0];
    end
  end

  // ==========================================================
  // pattern enable, timer control, bus release control
  logic [7:0] pat_en_q;
  logic [17:0] tmr_ctl_q;
  logic [3:0] bus_rel_q;
  always_ff @(posedge clk) begin
    if (regs_clear) begin
      pat_en_q <= pagpio_pkg::PAT_EN_RST;
    end else if (wr_go && wr_pat && wr_lane0) begin
      pat_en_q <= wr_data[7:0];
    end
  end
  always_ff @(posedge clk) begin
    if (regs_clear) begin
      tmr_ctl_q <= pagpio_pkg::TMR_CTL_RST;
    end else if (wr_go && wr_tmr) begin
      if (wr_lane0) begin
        tmr_ctl_q[7:0] <= wr_data[7:0];
      end
      if (wr_lane1) begin
        tmr_ctl_q[15:8] <= wr_data[15:8];
      end
      if (wr_lane2) begin
        tmr_ctl_q[17:16] <= wr_data[17:16];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (regs_clear) begin
      bus_rel_q <= pagpio_pkg::BUS_REL_RST;
    end else if (wr_go && wr_bus && wr_lane0) begin
      bus_rel_q <= wr_data[3:0];
    end
  end

  // ==========================================================
  // write response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= pagpio_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? pagpio_pkg::RESP_OKAY
                        : pagpio_pkg::RESP_SLVERR;
    end else if (axil_req.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================
  // pin function selection
  logic [7:0] addr_sel;
  logic [7:0] addr_val;
  logic [7:0] pwm_sel;
  logic [23:0] io_ctl;
  logic [7:0] cmp_val;
  logic [7:0] cap_tap;
  logic [7:0] drv_o;
  logic [7:0] drv_oe;

  always_comb begin
    addr_sel = 8'h00;
    addr_val = 8'h00;
    if (addr_mode) begin
      addr_sel[7] = 1'b1;
      addr_val[7] = addr_hi[0];
    end else if (exp_mode) begin
      // enable bits are active low: zero hands the pin to the bus
      addr_sel[7] = !bus_rel_q[0];
      addr_sel[6] = !bus_rel_q[1];
      addr_sel[5] = !bus_rel_q[2];
      addr_sel[4] = !bus_rel_q[3];
      addr_val[7] = addr_hi[0];
      addr_val[6] = addr_hi[1];
      addr_val[5] = addr_hi[2];
      addr_val[4] = addr_hi[3];
    end
  end

  // pins 3..0 have no timer hookup here, so their controls stay zero
  assign pwm_sel = {{2{tmr_ctl_q[pagpio_pkg::C2_PWM_BIT]}},
                    {2{tmr_ctl_q[pagpio_pkg::C1_PWM_BIT]}}, 4'h0};
  assign io_ctl = {tmr_ctl_q[pagpio_pkg::C2B_LSB +: 3],
                   tmr_ctl_q[pagpio_pkg::C2A_LSB +: 3],
                   tmr_ctl_q[pagpio_pkg::C1B_LSB +: 3],
                   tmr_ctl_q[pagpio_pkg::C1A_LSB +: 3], 12'h000};
  assign cmp_val = {chan2_b_cmp, chan2_a_cmp,
                    chan1_b_cmp, chan1_a_cmp, 4'h0};

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      pagpio_pinsel #(
        .B_SIDE((gi % 2) == 1)
      ) u_sel (
        .dir(dir_q[gi]),
        .data(data_q[gi]),
        .pat_en(pat_en_q[gi]),
        .pat_val(pattern_val[gi]),
        .pwm(pwm_sel[gi]),
        .io_ctl(io_ctl[3*gi +: 3]),
        .cmp_val(cmp_val[gi]),
        .addr_sel(addr_sel[gi]),
        .addr_val(addr_val[gi]),
        .pin_in(pin_i[gi]),
        .pin_out(drv_o[gi]),
        .pin_oe(drv_oe[gi]),
        .cap_out(cap_tap[gi])
      );
    end
  endgenerate

  // pins float while the chip sits in hardware standby
  assign pin_o = drv_o;
  assign pin_oe = hw_standby ? 8'h00 : drv_oe;
  assign chan1_a_cap = cap_tap[4];
  assign chan1_b_cap = cap_tap[5];
  assign chan2_a_cap = cap_tap[6];
  assign chan2_b_cap = cap_tap[7];

  // ==========================================================
  // read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic rd_take;
  logic [7:0] port_view;

  assign rd_take = axil_req.arvalid && !rvalid_q;
  assign port_view = (dir_q & data_q) | (~dir_q & pin_i);

  always_comb begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b0;
    if (axil_req.araddr[31:pagpio_pkg::IDX_MSB+1] == '0) begin
      rd_hit = 1'b1;
      case (axil_req.araddr[pagpio_pkg::IDX_MSB:pagpio_pkg::IDX_LSB])
        pagpio_pkg::DIR_IDX: rd_mux[7:0] = pagpio_pkg::DIR_READ_VAL;
        pagpio_pkg::DATA_IDX: rd_mux[7:0] = port_view;
        pagpio_pkg::PAT_EN_IDX: rd_mux[7:0] = pat_en_q;
        pagpio_pkg::TMR_CTL_IDX: rd_mux[17:0] = tmr_ctl_q;
        pagpio_pkg::BUS_REL_IDX: rd_mux[3:0] = bus_rel_q;
        pagpio_pkg::STATUS_IDX: begin
          rd_mux[7:0] = pin_i;
          rd_mux[pagpio_pkg::ST_OE_LSB +: 8] = pin_oe;
          rd_mux[pagpio_pkg::ST_MODE_LSB +: 3] = mode;
          rd_mux[pagpio_pkg::ST_MODE_LSB+3] = sw_standby;
        end
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
    end else if (axil_req.rready) begin
      rvalid_q <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_q <= 32'h00000000;
      rresp_q <= pagpio_pkg::RESP_OKAY;
    end else if (rd_take) begin
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? pagpio_pkg::RESP_OKAY
                        : pagpio_pkg::RESP_SLVERR;
    end
  end

  // ==========================================================
  // bus outputs
  always_comb begin
    axil_rsp.awready = aw_ready;
    axil_rsp.wready = w_ready;
    axil_rsp.bvalid = bvalid_q;
    axil_rsp.bresp = bresp_q;
    axil_rsp.arready = !rvalid_q;
    axil_rsp.rvalid = rvalid_q;
    axil_rsp.rdata = rdata_q;
    axil_rsp.rresp = rresp_q;
  end
endmodule : pagpio_top

// ==== sim/pagpio_board.sv ====
`timescale 1ns/1ps
// ==========================================================
// board side of the port pins
module pagpio_board (
  // board level on undriven pins
  input wire logic [7:0] lvl,
  // port pins
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_i
);
  // a driven pin reads back its own drive; no contention is modelled
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & lvl);
endmodule : pagpio_board

// ==== sim/pagpio_chk_properties.sv ====
`timescale 1ns/1ps
// ==========================================================
// pin and bus checks
module pagpio_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register bus
  input wire pagpio_pkg::pagpio_axil_req_t axil_req,
  input wire pagpio_pkg::pagpio_axil_rsp_t axil_rsp,
  // chip state
  input wire logic [2:0] mode,
  input wire logic hw_standby,
  input wire logic [3:0] addr_hi,
  // pins
  input wire logic chan1_b_cap,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe
);
  localparam logic [31:0] A_DIR = {10'h000, pagpio_pkg::DIR_IDX, 2'h0};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ar;
    axil_req.arvalid && axil_rsp.arready;
  endsequence
  sequence s_wr;
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid &&
      axil_rsp.wready;
  endsequence
  chk_addr_pin7: assert property (
    (mode == 3'h3 || mode == 3'h4) |-> pin_oe[7] && pin_o[7] == addr_hi[0])
    else $error("pin7 not address");
  chk_hw_idle: assert property (
    hw_standby && $past(hw_standby) && mode != 3'h3 && mode != 3'h4
    |-> pin_oe == 8'h00) else $error("pins driven in standby");
  chk_dir_ones: assert property (
    s_ar ##0 (axil_req.araddr == A_DIR) |=>
    axil_rsp.rdata == 32'h000000FF) else $error("direction read");
  chk_cap_gate: assert property (
    chan1_b_cap |-> pin_i[5]) else $error("capture without level");
  chk_unmapped_rd: assert property (
    s_ar ##0 (axil_req.araddr[31:22] != 10'h000) |=>
    axil_rsp.rresp == pagpio_pkg::RESP_SLVERR) else $error("bad read ok");
  chk_status_wr: assert property (
    s_wr ##0 (axil_req.awaddr == 32'h00000010) |->
    ##2 axil_rsp.bresp == pagpio_pkg::RESP_SLVERR) else $error("status wr");
  chk_wr_lat: assert property (
    s_wr |-> ##2 axil_rsp.bvalid) else $error("write response late");
  chk_rd_lat: assert property (
    s_ar |=> axil_rsp.rvalid) else $error("read response late");
endmodule : pagpio_chk

bind pagpio_top pagpio_chk u_chk (.clk(clk), .rst_n(rst_n),
  .axil_req(axil_req), .axil_rsp(axil_rsp), .mode(mode),
  .hw_standby(hw_standby), .addr_hi(addr_hi), .chan1_b_cap(chan1_b_cap),
  .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));

// ==== sim/port_a_pin_mux_io_tb.sv ====
`timescale 1ns/1ps
// ==========================================================
// port bench
module port_a_pin_mux_io_tb;
  localparam logic [31:0] A_DIR = {10'h000, pagpio_pkg::DIR_IDX, 2'h0};
  localparam logic [31:0] A_DAT = {10'h000, pagpio_pkg::DATA_IDX, 2'h0};
  localparam logic [1:0] OK = pagpio_pkg::RESP_OKAY;
  localparam logic [1:0] ER = pagpio_pkg::RESP_SLVERR;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  pagpio_pkg::pagpio_axil_req_t req = '0;
  pagpio_pkg::pagpio_axil_rsp_t rsp;
  logic [2:0] mode = 3'h1;
  logic hw_sb = 1'b0;
  logic sw_sb = 1'b0;
  logic [3:0] cmp = 4'h0;
  wire logic [3:0] cap;
  logic [7:0] lvl = 8'h3C;
  logic [7:0] pin_i;
  logic [7:0] pin_o;
  logic [7:0] pin_oe;
  int mismatches = 0;
  int n_compared = 0;
  always #10 clk = ~clk;
  pagpio_top u_dut (.clk(clk), .rst_n(rst_n), .axil_req(req),
    .axil_rsp(rsp), .mode(mode), .hw_standby(hw_sb), .sw_standby(sw_sb),
    .pattern_val(8'h69), .chan1_a_cmp(cmp[0]), .chan1_b_cmp(cmp[1]),
    .chan2_a_cmp(cmp[2]), .chan2_b_cmp(cmp[3]), .addr_hi(4'h5),
    .chan1_a_cap(cap[0]), .chan1_b_cap(cap[1]), .chan2_a_cap(cap[2]),
    .chan2_b_cap(cap[3]), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe));
  pagpio_board u_board (.lvl(lvl), .pin_o(pin_o), .pin_oe(pin_oe),
    .pin_i(pin_i));
  // ==========================================================
  // compares and bus cycles
  task automatic miss(input logic [31:0] g, input logic [31:0] e);
    mismatches++;
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
  endtask : miss
  task automatic ck8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) miss(32'(g), 32'(e));
  endtask : ck8
  task automatic ck32(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) miss(g, e);
  endtask : ck32
  task automatic ck2(input logic [1:0] g, input logic [1:0] e);
    n_compared++;
    if (g !== e) miss(32'(g), 32'(e));
  endtask : ck2
  task automatic rst(input logic [2:0] m);
    @(posedge clk);
    mode <= m;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask : rst
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
    input logic [1:0] e);
    bit aw;
    bit w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (!aw && rsp.awready) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!rsp.bvalid);
    req.bready <= 1'b0;
    ck2(rsp.bresp, e);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge clk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge clk);
    req.rready <= 1'b0;
    ck32(rsp.rdata, e);
    ck2(rsp.rresp, er);
  endtask : rd
  // only driven bits of the pin value are meaningful
  task automatic pins(input logic [7:0] oe, input logic [7:0] o);
    @(negedge clk);
    ck8(pin_oe, oe);
    ck8(pin_o & oe, o);
  endtask : pins
  // ==========================================================
  // scenarios
  task automatic t_gpio;
    rst(3'h1);
    pins(8'h00, 8'h00);
    rd(A_DIR, 32'hFF, OK);
    wr(A_DIR, 32'h0F, OK);
    wr(A_DAT, 32'hA5, OK);
    pins(8'h0F, 8'h05);
    rd(A_DAT, 32'h35, OK);
    wr(32'h4, 32'h3C, OK);
    pins(8'h0F, 8'h09);
  endtask : t_gpio
  task automatic t_tmr;
    rst(3'h1);
    wr(A_DIR, 32'hCF, OK);
    wr(32'h8, 32'h21040, OK);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      cmp <= {v[0], ~v[0], 2'h0};
      lvl[5] <= ~v[0];
      pins(8'hCF, {v[0], ~v[0], 6'h00});
      ck8({4'h0, cap}, {6'h00, ~v[0], 1'b0});
    end
    @(posedge clk);
    lvl <= 8'h3C;
  endtask : t_tmr
  task automatic t_addr;
    rst(3'h5);
    wr(32'hC, 32'hE, OK);
    pins(8'h80, 8'h80);
    wr(32'hC, 32'h0, OK);
    pins(8'hF0, 8'hA0);
    wr(32'hC, 32'hF, OK);
    pins(8'h00, 8'h00);
    for (int m = 3; m < 5; m++) begin
      rst(m[2:0]);
      pins(8'h80, 8'h80);
      wr(A_DIR, 32'h00, OK);
      pins(8'h80, 8'h80);
      rd(A_DAT, 32'h3C, OK);
    end
  endtask : t_addr
  task automatic t_stby;
    rst(3'h1);
    wr(A_DIR, 32'h0F, OK);
    wr(A_DAT, 32'h03, OK);
    @(posedge clk) sw_sb <= 1'b1;
    pins(8'h0F, 8'h03);
    rd(A_DAT, 32'h33, OK);
    rd(32'h10, 32'h00090F33, OK);
    @(posedge clk) sw_sb <= 1'b0;
    hw_sb <= 1'b1;
    repeat (2) pins(8'h00, 8'h00);
    @(posedge clk) hw_sb <= 1'b0;
    pins(8'h00, 8'h00);
    wr(A_DIR, 32'hFF, OK);
    pins(8'hFF, 8'h00);
  endtask : t_stby
  task automatic t_bad;
    rst(3'h1);
    rd(32'h14, 32'h0, ER);
    rd(32'h00400000, 32'h0, ER);
    wr(32'h14, 32'h1, ER);
    wr(32'h10, 32'h1, ER);
  endtask : t_bad
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  initial begin
    t_gpio();
    t_tmr();
    t_addr();
    t_stby();
    t_bad();
    print_verdict();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule : port_a_pin_mux_io_tb
